// [hw/quad_fabric_cfg.svh]
// constants for the quad processor memory and tdm fabric
`ifndef QUAD_FABRIC_CFG_SVH
`define QUAD_FABRIC_CFG_SVH
`define NPROC          4
`define TDM_SLOTS      128
`define TDM_SLOT_W     7
`define SLOTS_PER_PROC 32
`define SLOT_IDX_W     5
`define MEM_AW         17
`define MEM_DW         16
`define UNIFIED_BIT    16
`define TDM_IN_BASE    17'h0FF00
`define TDM_OUT_BASE   17'h0FF80
`define GLB_AW         32
`define DMA_LEN_W      16
`define IRQ_N          5
`define IRQ_GLOBAL     0
`define IRQ_HOST       1
`define IRQ_TDM        2
`define IRQ_MEMWR      3
`define IRQ_DMA        4
`define TDM_SEL_FRAME  1'b0
`define TDM_SEL_SUPER  1'b1
`endif

// [hw/quad_fabric_pkg.sv]
// shared types for the quad processor memory and tdm fabric
`include "quad_fabric_cfg.svh"
package quad_fabric_pkg;
    typedef struct packed {
        logic                 vld;
        logic                 we;
        logic [`MEM_AW-1:0]   addr;
        logic [`MEM_DW-1:0]   wdata;
    } mem_req_t;
    typedef struct packed {
        logic                 to_global;
        logic [`MEM_AW-1:0]   laddr;
        logic [`GLB_AW-1:0]   gaddr;
        logic [`DMA_LEN_W-1:0] len;
    } dma_cmd_t;
    typedef struct packed {
        logic                 vld;
        logic                 we;
        logic [`GLB_AW-1:0]   addr;
        logic [`MEM_DW-1:0]   wdata;
    } glb_req_t;
    typedef struct packed {
        logic                   vld;
        logic [`TDM_SLOT_W-1:0] slot;
        logic                   rx_en;
        logic                   tx_en;
        logic [7:0]             rx_byte;
    } tdm_slot_t;
    typedef enum logic [5:0] {
        DMA_IDLE = 6'h01,
        DMA_LRD  = 6'h02,
        DMA_LWT  = 6'h04,
        DMA_GWR  = 6'h08,
        DMA_GRD  = 6'h10,
        DMA_LWR  = 6'h20
    } dma_state_t;
endpackage : quad_fabric_pkg

// [hw/local_bank_mem.sv]
// single port local memory bank with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "quad_fabric_cfg.svh"
module local_bank_mem #(
    parameter int AW = `MEM_AW,
    parameter int DW = `MEM_DW
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_en,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    if (AW < 7 || DW < 8) begin : g_chk
        $error("local_bank_mem: width too small");
    end
    logic [DW-1:0] mem [2**AW];
    always_ff @(posedge i_clk) begin
        if (i_en && i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_en && !i_we) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule : local_bank_mem
`default_nettype wire

// [hw/quad_fabric.sv]
// four local memory banks, shared dma engine, tdm slot buffers and interrupt routing
// Summary of operation
// RULE1: 128 tdm slots split among four processors
// RULE2: each processor 32 rx and 32 tx bytes
// RULE3: one tdm frame latency each direction
// RULE4: frame or multiframe event as processor interrupt
// RULE5: bank served to processor, pci and dma
// RULE6: one shared dma, never bank to bank
// RULE7: each bank 256 Kbytes of 16-bit words
// RULE8: unified variant forces address bit 16 high
// RULE9: off-module data reached only through dma copies
// RULE10: selectable tdm, dma, pci and memory interrupts
// RULE11: processors raise pci int-a and int-b
// RULE12: host decides whether pci lines interrupt it (here o_pci_int_a is the unmasked OR of every status bit 0, and o_pci_int_b of every status bit 1)
// RULE13: carrier revision decides which line goes global (no revision input here: i_pci_global_irq sets every global flag)
// RULE14: one wait state for fast processor clock
// RULE15: dma arbitrates, one transfer, completion to requester
// RULE16: pingpong selector toggles only at frame boundary
// RULE17: event select 0 frame, 1 superframe
// RULE18: pci status bits clear when host reads
// RULE19: host programs tdm count as slots minus two (here there is no tdm count: a fixed 128 slots are decoded from i_tdm.slot)
`timescale 1ns/1ps
`default_nettype none
`include "quad_fabric_cfg.svh"
module quad_fabric
    import quad_fabric_pkg::*;
#(
    parameter int NPROC = `NPROC
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst,
    input  wire logic                             i_unified,
    input  wire logic                             i_one_wait,
    input  wire mem_req_t [NPROC-1:0]             i_proc_req,
    output logic          [NPROC-1:0]             o_proc_ack,
    output logic          [NPROC-1:0][`MEM_DW-1:0] o_proc_rdata,
    input  wire mem_req_t                         i_pci_req,
    input  wire logic     [1:0]                   i_pci_bank,
    output logic                                  o_pci_rdy,
    output logic                                  o_pci_rvld,
    output logic          [`MEM_DW-1:0]           o_pci_rdata,
    input  wire logic     [NPROC-1:0]             i_dma_start,
    input  wire dma_cmd_t [NPROC-1:0]             i_dma_cmd,
    output logic                                  o_dma_busy,
    output logic          [NPROC-1:0]             o_dma_done,
    output glb_req_t                              o_glb_req,
    input  wire logic                             i_glb_ack,
    input  wire logic     [`MEM_DW-1:0]           i_glb_rdata,
    input  wire tdm_slot_t                        i_tdm,
    input  wire logic                             i_tdm_frame,
    input  wire logic                             i_tdm_superframe,
    output logic                                  o_tdm_tx_vld,
    output logic          [7:0]                   o_tdm_tx_byte,
    output logic                                  o_tdm_pingpong_select,
    input  wire logic     [NPROC-1:0]             i_tdm_event_irq_select,
    input  wire logic     [NPROC-1:0][`IRQ_N-1:0] i_irq_en,
    input  wire logic     [NPROC-1:0][`IRQ_N-1:0] i_irq_clr,
    input  wire logic     [NPROC-1:0]             i_host_irq_set,
    input  wire logic                             i_pci_global_irq,
    output logic          [NPROC-1:0]             o_proc_irq,
    output logic          [NPROC-1:0][`IRQ_N-1:0] o_irq_flags,
    input  wire logic     [NPROC-1:0][1:0]        i_proc_pci_int_set,
    input  wire logic                             i_irq_status_rd,
    output logic          [NPROC-1:0][1:0]        o_pci_int_status,
    output logic                                  o_pci_int_a,
    output logic                                  o_pci_int_b
);
    // slot owner decode is slot[6:5], so only this split is served
    if (NPROC != 4 || NPROC * `SLOTS_PER_PROC != `TDM_SLOTS) begin : g_chk
        $error("quad_fabric: needs four processors sharing 128 slots");
    end

    logic [NPROC-1:0]              dma_gnt, pci_gnt, pci_rd_q;
    logic [NPROC-1:0][`MEM_DW-1:0] bank_rdata;
    mem_req_t                      dma_req;

    // ---------------- tdm slot path ----------------
    logic      sel_q, sel_d, txo_vld_q, txo_vld_d, tx_vld_q, tx_vld_d;
    tdm_slot_t txs_q, txs_d;
    logic [1:0] txo_own_q, txo_own_d;
    logic [7:0] tx_byte_q, tx_byte_d;

    always_comb begin
        sel_d     = i_tdm_frame ? ~sel_q : sel_q;        // see RULE16
        txs_d     = i_tdm;
        txs_d.vld = i_tdm.vld & i_tdm.tx_en;
        txo_vld_d = txs_q.vld;
        txo_own_d = txs_q.slot[`TDM_SLOT_W-1 -: 2];
        tx_vld_d  = txo_vld_q;
        tx_byte_d = txo_vld_q ? bank_rdata[txo_own_q][7:0] : tx_byte_q;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sel_q     <= 1'b0;
            txs_q     <= '0;
            txo_vld_q <= 1'b0;
            txo_own_q <= 2'h0;
            tx_vld_q  <= 1'b0;
            tx_byte_q <= 8'h00;
        end else begin
            sel_q     <= sel_d;
            txs_q     <= txs_d;
            txo_vld_q <= txo_vld_d;
            txo_own_q <= txo_own_d;
            tx_vld_q  <= tx_vld_d;
            tx_byte_q <= tx_byte_d;
        end
    end
    assign o_tdm_pingpong_select = sel_q;
    assign o_tdm_tx_vld          = tx_vld_q;
    assign o_tdm_tx_byte         = tx_byte_q;

    // ---------------- shared dma engine ----------------
    dma_state_t             st_q, st_d;
    logic [NPROC-1:0]       pend_q, pend_d, done_q, done_d;
    logic [1:0]             cur_q, cur_d, rr_q, rr_d;
    logic [`MEM_AW-1:0]     la_q, la_d;
    logic [`GLB_AW-1:0]     ga_q, ga_d;
    logic [`DMA_LEN_W-1:0]  rem_q, rem_d;
    logic [`MEM_DW-1:0]     dat_q, dat_d;

    always_comb begin
        logic       found;
        logic [1:0] idx;
        found  = 1'b0;
        idx    = 2'h0;
        st_d   = st_q;
        pend_d = pend_q | i_dma_start;                   // see RULE15
        done_d = '0;
        cur_d  = cur_q;
        rr_d   = rr_q;
        la_d   = la_q;
        ga_d   = ga_q;
        rem_d  = rem_q;
        dat_d  = dat_q;
        case (st_q)
            DMA_IDLE: begin
                // round robin from the last served requester
                for (int i = 1; i <= NPROC; i++) begin
                    if (!found && pend_q[2'(rr_q + 2'(i))]) begin
                        found = 1'b1;
                        idx   = 2'(rr_q + 2'(i));
                    end
                end
                if (found) begin
                    pend_d[idx] = i_dma_start[idx];     // a new start re-queues
                    cur_d = idx;
                    rr_d  = idx;
                    la_d  = i_dma_cmd[idx].laddr;
                    ga_d  = i_dma_cmd[idx].gaddr;
                    rem_d = i_dma_cmd[idx].len;
                    if (i_dma_cmd[idx].len == '0) begin
                        done_d[idx] = 1'b1;
                    end else begin
                        st_d = i_dma_cmd[idx].to_global ? DMA_LRD : DMA_GRD;
                    end
                end
            end
            DMA_LRD: if (dma_gnt[cur_q]) st_d = DMA_LWT;
            DMA_LWT: begin
                dat_d = bank_rdata[cur_q];
                st_d  = DMA_GWR;
            end
            DMA_GRD: begin
                if (i_glb_ack) begin
                    dat_d = i_glb_rdata;
                    st_d  = DMA_LWR;
                end
            end
            DMA_GWR, DMA_LWR: begin
                if ((st_q == DMA_GWR) ? i_glb_ack : dma_gnt[cur_q]) begin
                    la_d  = la_q + 1'b1;
                    ga_d  = ga_q + 1'b1;
                    rem_d = rem_q - 1'b1;
                    if (rem_q == `DMA_LEN_W'(1)) begin
                        done_d[cur_q] = 1'b1;            // see RULE15
                        st_d = DMA_IDLE;
                    end else begin
                        st_d = (st_q == DMA_GWR) ? DMA_LRD : DMA_GRD;
                    end
                end
            end
            default: st_d = DMA_IDLE;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q   <= DMA_IDLE;
            pend_q <= '0;
            done_q <= '0;
            cur_q  <= 2'h0;
            rr_q   <= 2'h3;
            la_q   <= '0;
            ga_q   <= '0;
            rem_q  <= '0;
            dat_q  <= '0;
        end else begin
            st_q   <= st_d;
            pend_q <= pend_d;
            done_q <= done_d;
            cur_q  <= cur_d;
            rr_q   <= rr_d;
            la_q   <= la_d;
            ga_q   <= ga_d;
            rem_q  <= rem_d;
            dat_q  <= dat_d;
        end
    end
    // only the selected bank ever sees the engine: no bank to bank path
    assign dma_req.vld   = (st_q == DMA_LRD) || (st_q == DMA_LWR);  // see RULE6
    assign dma_req.we    = (st_q == DMA_LWR);
    assign dma_req.addr  = la_q;
    assign dma_req.wdata = dat_q;
    assign o_glb_req.vld   = (st_q == DMA_GWR) || (st_q == DMA_GRD); // see RULE9
    assign o_glb_req.we    = (st_q == DMA_GWR);
    assign o_glb_req.addr  = ga_q;
    assign o_glb_req.wdata = dat_q;
    assign o_dma_busy = (st_q != DMA_IDLE);
    assign o_dma_done = done_q;

    // ---------------- per processor bank and interrupts ----------------
    for (genvar p = 0; p < NPROC; p++) begin : g_proc
        mem_req_t             req;
        logic                 g_dma, g_pci, g_proc, tdm_w, tdm_r;
        logic                 busy_q, busy_d, rd_q, rd_d, rd2_q, prd_q, prd_d;
        logic [`MEM_DW-1:0]   pdat_q, pdat_d;
        logic [`IRQ_N-1:0]    fl_q, fl_d, set;
        logic [1:0]           ps_q, ps_d;

        // tdm first: slot timing cannot wait, other requesters stall
        always_comb begin
            tdm_w  = i_tdm.vld && i_tdm.rx_en &&
                     (i_tdm.slot[`TDM_SLOT_W-1 -: 2] == 2'(p));    // see RULE1
            tdm_r  = txs_q.vld && (txs_q.slot[`TDM_SLOT_W-1 -: 2] == 2'(p));
            g_dma  = 1'b0;
            g_pci  = 1'b0;
            g_proc = 1'b0;
            req    = '0;
            // device fills the buffer the processors are not using
            if (tdm_w) begin                                    // see RULE2
                req.vld   = 1'b1;
                req.we    = 1'b1;
                req.addr  = `TDM_IN_BASE + {~sel_q, i_tdm.slot[`SLOT_IDX_W-1:0]};
                req.wdata = {8'h00, i_tdm.rx_byte};
            end else if (tdm_r) begin                           // see RULE3
                req.vld   = 1'b1;
                req.addr  = `TDM_OUT_BASE + {~sel_q, txs_q.slot[`SLOT_IDX_W-1:0]};
            end else if (dma_req.vld && cur_q == 2'(p)) begin  // see RULE5
                req   = dma_req;
                g_dma = 1'b1;
            end else if (i_pci_req.vld && i_pci_bank == 2'(p)) begin
                req   = i_pci_req;
                g_pci = 1'b1;
            // request is still held while its ack stands: no second grant
            end else if (i_proc_req[p].vld && !busy_q && !o_proc_ack[p]) begin
                req    = i_proc_req[p];
                g_proc = 1'b1;
            end
            if (i_unified) begin
                req.addr[`UNIFIED_BIT] = 1'b1;                 // see RULE8
            end
            busy_d = g_proc & i_one_wait;                       // see RULE14
            rd_d   = g_proc;
            prd_d  = g_pci & ~req.we;
            pdat_d = rd_q ? bank_rdata[p] : pdat_q;
        end

        local_bank_mem #(
            .AW (`MEM_AW),
            .DW (`MEM_DW)
        ) u_bank (                                              // see RULE7
            .i_clk   (i_clk),
            .i_rst   (i_rst),
            .i_en    (req.vld),
            .i_we    (req.we),
            .i_addr  (req.addr),
            .i_wdata (req.wdata),
            .o_rdata (bank_rdata[p])
        );

        always_comb begin
            set = '0;
            set[`IRQ_GLOBAL] = i_pci_global_irq;
            set[`IRQ_HOST]   = i_host_irq_set[p];
            set[`IRQ_TDM]    = (i_tdm_event_irq_select[p] == `TDM_SEL_SUPER) ?
                               i_tdm_superframe : i_tdm_frame;  // see RULE4 see RULE17
            set[`IRQ_MEMWR]  = g_pci & req.we;
            set[`IRQ_DMA]    = done_q[p];
            fl_d = (fl_q & ~i_irq_clr[p]) | set;                // see RULE10
            ps_d = (ps_q & ~{2{i_irq_status_rd}}) | i_proc_pci_int_set[p]; // see RULE11 see RULE18
        end

        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                busy_q <= 1'b0;
                rd_q   <= 1'b0;
                rd2_q  <= 1'b0;
                prd_q  <= 1'b0;
                pdat_q <= '0;
                fl_q   <= '0;
                ps_q   <= 2'h0;
            end else begin
                busy_q <= busy_d;
                rd_q   <= rd_d;
                rd2_q  <= rd_q;
                prd_q  <= prd_d;
                pdat_q <= pdat_d;
                fl_q   <= fl_d;
                ps_q   <= ps_d;
            end
        end

        assign dma_gnt[p]  = g_dma;
        assign pci_gnt[p]  = g_pci;
        assign pci_rd_q[p] = prd_q;
        // the wait state holds the answer one more cycle
        assign o_proc_ack[p]       = i_one_wait ? rd2_q : rd_q;   // see RULE14
        assign o_proc_rdata[p]     = i_one_wait ? pdat_q : bank_rdata[p];
        assign o_irq_flags[p]      = fl_q;
        assign o_proc_irq[p]       = |(fl_q & i_irq_en[p]);
        assign o_pci_int_status[p] = ps_q;
    end

    always_comb begin
        o_pci_rdata = '0;
        o_pci_int_a = 1'b0;
        o_pci_int_b = 1'b0;
        for (int i = 0; i < NPROC; i++) begin
            if (pci_rd_q[i]) o_pci_rdata = bank_rdata[i];
            o_pci_int_a = o_pci_int_a | o_pci_int_status[i][0];
            o_pci_int_b = o_pci_int_b | o_pci_int_status[i][1];
        end
    end
    assign o_pci_rdy  = |pci_gnt;
    assign o_pci_rvld = |pci_rd_q;
endmodule : quad_fabric
`default_nettype wire

// [testbench/quad_fabric_props.sv]
// port assertions for the quad fabric
`timescale 1ns/1ps
`default_nettype none
`include "quad_fabric_cfg.svh"
module quad_fabric_props
    import quad_fabric_pkg::*;
#(
    parameter int NPROC = `NPROC
) (
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire tdm_slot_t                i_tdm,
    input wire logic                     i_tdm_frame,
    input wire logic                     o_tdm_tx_vld,
    input wire logic                     o_tdm_pingpong_select,
    input wire logic [NPROC-1:0]         i_tdm_event_irq_select,
    input wire logic [NPROC-1:0][4:0]    o_irq_flags,
    input wire logic [NPROC-1:0]         o_dma_done,
    input wire glb_req_t                 o_glb_req,
    input wire logic                     i_glb_ack,
    input wire logic [NPROC-1:0][1:0]    i_proc_pci_int_set,
    input wire logic                     i_irq_status_rd,
    input wire logic                     o_pci_int_a,
    input wire logic                     o_pci_int_b
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic tx_req;
    assign tx_req = i_tdm.vld & i_tdm.tx_en;
    property p_pp_flip;
        i_tdm_frame |=> o_tdm_pingpong_select != $past(o_tdm_pingpong_select);
    endproperty
    a_pp_flip: assert property (p_pp_flip) else $error("selector missed a frame");
    property p_pp_hold;
        !i_tdm_frame |=> $stable(o_tdm_pingpong_select);
    endproperty
    a_pp_hold: assert property (p_pp_hold) else $error("selector moved mid frame");
    property p_tx_lat;
        tx_req |-> ##3 o_tdm_tx_vld;
    endproperty
    a_tx_lat: assert property (p_tx_lat) else $error("tx byte late");
    property p_tx_only;
        o_tdm_tx_vld |-> $past(tx_req, 3);
    endproperty
    a_tx_only: assert property (p_tx_only) else $error("tx byte without slot");
    property p_done_one;
        $onehot0(o_dma_done);
    endproperty
    a_done_one: assert property (p_done_one) else $error("done to several");
    property p_glb_hold;
        o_glb_req.vld && !i_glb_ack |=> $stable(o_glb_req);
    endproperty
    a_glb_hold: assert property (p_glb_hold) else $error("global request dropped");
    property p_int_set;
        (i_proc_pci_int_set & {NPROC{2'b10}}) != '0 |=> o_pci_int_b;
    endproperty
    a_int_set: assert property (p_int_set) else $error("int b not raised");
    property p_int_clr;
        i_irq_status_rd && i_proc_pci_int_set == '0 |=> !o_pci_int_a && !o_pci_int_b;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("status not cleared");
    property p_flag;
        i_tdm_frame && i_tdm_event_irq_select[0] == `TDM_SEL_FRAME |=> o_irq_flags[0][`IRQ_TDM];
    endproperty
    a_flag: assert property (p_flag) else $error("frame flag missing");
endmodule : quad_fabric_props
bind quad_fabric quad_fabric_props #(.NPROC(NPROC)) u_props (.*);
`default_nettype wire

// [testbench/glb_mem_model.sv]
// global memory responder behind the dma port
`timescale 1ns/1ps
`default_nettype none
module glb_mem_model
    import quad_fabric_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_delay,
    input  wire glb_req_t   i_req,
    output logic            o_ack,
    output logic [15:0]     o_rdata
);
    logic [15:0] mem [0:15];
    logic [1:0]  wait_q;
    always_ff @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata; // never leave stale data between answers
        if (i_rst) begin
            wait_q <= 2'h0;
            o_rdata <= 16'h0000;
        end else if (i_req.vld && !o_ack) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == i_delay) begin
                o_ack <= 1'b1;
                wait_q <= 2'h0;
                if (i_req.we) mem[i_req.addr[3:0]] <= i_req.wdata;
                else o_rdata <= mem[i_req.addr[3:0]];
            end
        end
    end
endmodule : glb_mem_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the quad fabric
`timescale 1ns/1ps
`default_nettype none
`include "quad_fabric_cfg.svh"
module testbench;
    import quad_fabric_pkg::*;
    typedef struct { logic [1:0] p; logic [16:0] a; logic [15:0] d; } row_t;
    logic             i_clk, i_rst, i_unified, i_one_wait, i_irq_status_rd, i_glb_ack;
    logic             o_pci_rdy, o_pci_rvld, o_dma_busy, o_pci_int_a, o_pci_int_b;
    logic             i_tdm_frame, i_tdm_superframe, i_pci_global_irq, o_tdm_tx_vld;
    logic             o_tdm_pingpong_select;
    logic [1:0]       i_pci_bank, glb_delay;
    logic [7:0]       o_tdm_tx_byte, seq;
    logic [15:0]      o_pci_rdata, i_glb_rdata, rd;
    logic [3:0]       i_dma_start, o_dma_done, o_proc_ack, i_tdm_event_irq_select;
    logic [3:0]       i_host_irq_set, o_proc_irq;
    mem_req_t [3:0]   i_proc_req;
    mem_req_t         i_pci_req;
    dma_cmd_t [3:0]   i_dma_cmd;
    glb_req_t         o_glb_req;
    tdm_slot_t        i_tdm;
    logic [3:0][15:0] o_proc_rdata;
    logic [3:0][4:0]  i_irq_en, i_irq_clr, o_irq_flags;
    logic [3:0][1:0]  i_proc_pci_int_set, o_pci_int_status;
    int               err_count, n_tests, lat, n;
    row_t             rows [4] = '{'{2'h0, 17'h00000, 16'h0001}, '{2'h1, 17'h0FFFF, 16'hFFFF},
                                   '{2'h2, 17'h1FFFF, 16'hA55A}, '{2'h3, 17'h10000, 16'h8000}};
    quad_fabric #(.NPROC(4)) uut (.*);
    glb_mem_model gm (.i_clk(i_clk), .i_rst(i_rst), .i_delay(glb_delay), .i_req(o_glb_req),
        .o_ack(i_glb_ack), .o_rdata(i_glb_rdata));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // request held until the edge that samples ack, then a few idle cycles
    task automatic pacc(input logic [1:0] p, input logic we, input logic [16:0] a,
                        input logic [15:0] d);
        lat = 0;
        @(posedge i_clk);
        i_proc_req[p] <= '{1'b1, we, a, d};
        while (!o_proc_ack[p] && lat < 20) begin
            @(negedge i_clk);
            lat++;
        end
        rd = o_proc_rdata[p];
        @(posedge i_clk);
        i_proc_req[p].vld <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask : pacc
    task automatic pci(input logic [1:0] b, input logic we, input logic [16:0] a,
                       input logic [15:0] d);
        @(posedge i_clk);
        i_pci_bank <= b;
        i_pci_req <= '{1'b1, we, a, d};
        n = 0;
        while (!o_pci_rdy && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        @(posedge i_clk);
        i_pci_req.vld <= 1'b0;
        @(negedge i_clk);
        rd = o_pci_rvld ? o_pci_rdata : 'x;
    endtask : pci
    task automatic slot(input logic [6:0] s, input logic rx, input logic tx, input logic [7:0] b);
        @(posedge i_clk);
        i_tdm <= '{1'b1, s, rx, tx, b};
        @(posedge i_clk);
        i_tdm.vld <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : slot
    task automatic pulse_frame(input logic sup);
        @(posedge i_clk);
        if (sup) i_tdm_superframe <= 1'b1;
        else i_tdm_frame <= 1'b1;
        @(posedge i_clk);
        {i_tdm_frame, i_tdm_superframe} <= 2'b00;
        @(negedge i_clk);
    endtask : pulse_frame
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        #40000;
        err_count++;
        give_verdict();
    end
    initial begin
        {err_count, n_tests, i_rst, glb_delay} = {32'h0, 32'h0, 1'b1, 2'h2};
        {i_unified, i_one_wait, i_proc_req, i_pci_req, i_pci_bank, i_dma_start, i_dma_cmd,
         i_tdm, i_tdm_frame, i_tdm_superframe, i_tdm_event_irq_select, i_irq_clr,
         i_host_irq_set, i_pci_global_irq, i_proc_pci_int_set, i_irq_status_rd} = '0;
        i_irq_en = '1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        check({o_tdm_pingpong_select, o_dma_busy, o_pci_int_a, o_pci_int_b}, 4'h0);
        check(o_irq_flags, 20'h00000);
        foreach (rows[i]) begin
            pacc(rows[i].p, 1'b1, rows[i].a, rows[i].d);
            pacc(rows[i].p, 1'b0, rows[i].a, 16'h0000);
            check(rd, rows[i].d);
            pci(rows[i].p, 1'b0, rows[i].a, 16'h0000);
            check(rd, rows[i].d);
        end
        check(lat, 2);
        i_one_wait <= 1'b1;
        pacc(2'h2, 1'b0, 17'h1FFFF, 16'h0000);
        check({lat[3:0], rd}, 20'h3A55A);
        i_one_wait <= 1'b0;
        i_unified <= 1'b1;
        pacc(2'h0, 1'b1, 17'h00044, 16'h1357);
        i_unified <= 1'b0;
        pacc(2'h0, 1'b0, 17'h10044, 16'h0000);
        check(rd, 16'h1357);
        pci(2'h3, 1'b1, 17'h00010, 16'h0BAD);
        @(negedge i_clk);
        check(o_irq_flags[3][`IRQ_MEMWR], 1'b1);
        pacc(2'h1, 1'b1, 17'h00100, 16'h1111);
        pacc(2'h1, 1'b1, 17'h00101, 16'h2222);
        i_dma_cmd[1] <= '{1'b1, 17'h00100, 32'h00000004, 16'h0002};
        i_dma_cmd[2] <= '{1'b0, 17'h00200, 32'h00000004, 16'h0002};
        i_dma_start <= 4'h6;
        @(posedge i_clk);
        i_dma_start <= 4'h0;
        {n, seq} = '0;
        while (seq[7:4] == 4'h0 && n < 400) begin
            @(negedge i_clk);
            n++;
            if (o_dma_done != 4'h0) seq = {seq[3:0], o_dma_done};
        end
        check(seq, 8'h24);
        check({gm.mem[5], gm.mem[4]}, 32'h22221111);
        pacc(2'h2, 1'b0, 17'h00201, 16'h0000);
        check(rd, 16'h2222);
        check({o_irq_flags[2][`IRQ_DMA], o_irq_flags[1][`IRQ_DMA]}, 2'b11);
        pacc(2'h1, 1'b1, 17'h0FF3F, 16'h1234);
        slot(7'h5F, 1'b1, 1'b0, 8'hA5);
        pulse_frame(1'b0);
        check({o_tdm_pingpong_select, o_irq_flags[0][`IRQ_TDM], o_proc_irq[0]}, 3'h7);
        pacc(2'h2, 1'b0, 17'h0FF3F, 16'h0000);
        check(rd, 16'h00A5);
        pacc(2'h1, 1'b0, 17'h0FF3F, 16'h0000);
        check(rd, 16'h1234);
        pacc(2'h3, 1'b1, 17'h0FFA0, 16'h003C);
        pulse_frame(1'b0);
        slot(7'h60, 1'b0, 1'b1, 8'h00);
        check({o_tdm_pingpong_select, o_tdm_tx_byte}, 9'h03C);
        i_tdm_event_irq_select[0] <= `TDM_SEL_SUPER;
        i_irq_clr[0] <= 5'h1F;
        @(posedge i_clk);
        i_irq_clr[0] <= 5'h00;
        pulse_frame(1'b0);
        check(o_irq_flags[0][`IRQ_TDM], 1'b0);
        pulse_frame(1'b1);
        check(o_irq_flags[0][`IRQ_TDM], 1'b1);
        i_irq_en[0] <= 5'h00;
        i_proc_pci_int_set[2] <= 2'b10;
        i_host_irq_set[3] <= 1'b1;
        i_pci_global_irq <= 1'b1;
        @(posedge i_clk);
        i_proc_pci_int_set[2] <= 2'b00;
        i_host_irq_set[3] <= 1'b0;
        @(negedge i_clk);
        check({o_pci_int_b, o_pci_int_a, o_pci_int_status[2], o_proc_irq[0]}, 5'h14);
        check(o_irq_flags[3][1:0], 2'b11);
        i_irq_status_rd <= 1'b1;
        @(posedge i_clk);
        i_irq_status_rd <= 1'b0;
        @(negedge i_clk);
        check({o_pci_int_b, o_pci_int_status}, 9'h000);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
